// ==== rtl/plz_pkg.sv ====
// Package holding object indices, bit positions and carrier types.
package plz_pkg;

  // ---------------------------------------------------------------
  // Object indices
  // ---------------------------------------------------------------
  localparam logic [15:0] OBJ_INPUT_FUNC   = 16'h2020;
  localparam logic [15:0] OBJ_STATUS_WORD  = 16'h6041;
  localparam logic [15:0] OBJ_LATCH_CTRL   = 16'h60B8;
  localparam logic [15:0] OBJ_LATCH_STATE  = 16'h60B9;
  localparam logic [15:0] OBJ_LATCH_POS    = 16'h60BA;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int IFN_COMP_REQ_BIT   = 0;
  localparam int SW_REACHED_BIT     = 10;
  localparam int SW_FOUND_BIT       = 12;
  localparam int SW_COMP_BIT        = 15;
  localparam int LC_ENABLE_BIT      = 0;
  localparam int LC_MODE_BIT        = 1;
  localparam int LC_ARM_BIT         = 4;
  localparam int LC_USED_BITS       = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] LATCH_CTRL_RST = 16'h0000;
  localparam logic [15:0] INPUT_FUNC_RST = 16'h0000;
  localparam logic [31:0] POS_RST        = 32'h0000_0000;

  // Latch state object, low byte meaningful, the rest reads zero.
  typedef struct packed {
    logic [23:0] zero;       // Upper bits, always zero.
    logic        cont_tog;   // Toggles on every continuous capture.
    logic [4:0]  rsvd;       // Reserved, zero.
    logic        captured;   // A position has been captured.
    logic        enabled;    // Capture unit is enabled.
  } plz_latch_state_s;

  // Homing report from the homing logic.
  typedef struct packed {
    logic reached;           // Target reached.
    logic found;             // Index signal found.
  } plz_homing_s;

endpackage : plz_pkg

// ==== rtl/plz_top.sv ====
// Homing compensation handshake and index-pulse position capture unit.
// The object port stands in for the fieldbus mailbox: one strobe, one
// index and one 32-bit word per access, 16-bit objects in the low half.
`timescale 1ns/1ps
module plz_top #(
  parameter int POS_W = 32                // Feedback position width.
) (
  input  wire logic              i_ref_clk,    // 125 MHz clock.
  input  wire logic              i_rst_b,      // Sync reset, active low.
  input  wire logic              i_obj_wr,     // Object write strobe.
  input  wire logic              i_obj_rd,     // Object read strobe.
  input  wire logic [15:0]       i_obj_idx,    // Object index.
  input  wire logic [31:0]       i_obj_wdata,  // Object write data.
  output logic      [31:0]       o_obj_rdata,  // Object read data.
  output logic                   o_obj_rvalid, // Read answer pulse.
  input  wire plz_pkg::plz_homing_s i_homing,  // Homing report.
  input  wire logic              i_enc_index,  // Encoder index pulse.
  input  wire logic [POS_W-1:0]  i_fb_pos,     // Feedback position.
  output logic                   o_fb_zero,    // Clear feedback to zero.
  output logic                   o_comp_on,    // Compensation active.
  output logic      [15:0]       o_status_word // Homing status bits.
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0]      input_func_r, input_func_nxt;
  logic [15:0]      latch_ctrl_r, latch_ctrl_nxt;
  logic             comp_r,       comp_nxt;
  logic             zero_r,       zero_nxt;
  logic [15:0]      sw_r,         sw_nxt;
  logic             index_d_r,    index_d_nxt;
  logic             arm_d_r,      arm_d_nxt;
  logic             armed_r,      armed_nxt;
  logic             capt_r,       capt_nxt;
  logic             tog_r,        tog_nxt;
  logic [POS_W-1:0] pos_r,        pos_nxt;
  logic [31:0]      rdata_r,      rdata_nxt;
  logic             rvalid_r,     rvalid_nxt;

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  logic             homing_done;
  logic             index_rise;
  logic             arm_rise;
  logic             lc_en;
  logic             lc_cont;
  logic             lc_arm;
  logic             take;
  plz_pkg::plz_latch_state_s state_w;

  // ---------------------------------------------------------------
  // Homing compensation handshake
  // ---------------------------------------------------------------
  // The request is only honoured while homing reports done, so a bit
  // set too early by the host simply waits for homing to finish.
  always_comb begin
    homing_done = i_homing.reached & i_homing.found;
    comp_nxt    = homing_done &
                  input_func_r[plz_pkg::IFN_COMP_REQ_BIT];
    // One zeroing pulse on the cycle compensation becomes active.
    zero_nxt    = comp_nxt & ~comp_r;
    // Bits 10 and 12 mirror the homing report one cycle late; they are not
    // latched, so a lost homing shows at once.
    sw_nxt      = 16'h0000;
    sw_nxt[plz_pkg::SW_REACHED_BIT] = i_homing.reached;
    sw_nxt[plz_pkg::SW_FOUND_BIT]   = i_homing.found;
    sw_nxt[plz_pkg::SW_COMP_BIT]    = comp_nxt;
  end

  // Status bits are registered beside the compensation flag so that bit 15
  // never shows without bits 10 and 12 in the same word.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      comp_r <= 1'b0;
      zero_r <= 1'b0;
      sw_r   <= 16'h0000;
    end else begin
      comp_r <= comp_nxt;
      zero_r <= zero_nxt;
      sw_r   <= sw_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Capture unit
  // ---------------------------------------------------------------
  always_comb begin
    lc_en       = latch_ctrl_r[plz_pkg::LC_ENABLE_BIT];
    lc_cont     = latch_ctrl_r[plz_pkg::LC_MODE_BIT];
    lc_arm      = latch_ctrl_r[plz_pkg::LC_ARM_BIT];
    index_d_nxt = i_enc_index;
    arm_d_nxt   = lc_arm;
    // The index must be seen low for a cycle between pulses; a pin held
    // high gives one capture only, never one per clock.
    index_rise  = i_enc_index & ~index_d_r;
    arm_rise    = lc_arm & ~arm_d_r;
    take        = lc_en & armed_r & index_rise;
    armed_nxt   = armed_r;
    capt_nxt    = capt_r;
    tog_nxt     = tog_r;
    pos_nxt     = pos_r;
    // A disarm written the cycle before an index edge wins, so that capture
    // is dropped rather than reported after the host has let go.
    if (!lc_en || !lc_arm) begin
      // Dropping enable or arm withdraws the capture request.
      armed_nxt = 1'b0;
      capt_nxt  = 1'b0;
    end else if (arm_rise) begin
      // A fresh arm edge starts a new handshake.
      armed_nxt = 1'b1;
      capt_nxt  = 1'b0;
    end else if (take) begin
      pos_nxt   = i_fb_pos;
      capt_nxt  = 1'b1;
      if (lc_cont) begin
        tog_nxt = ~tog_r;
      end else begin
        armed_nxt = 1'b0;
      end
    end
  end

  // The state word is built from registered flags only, so a read sees
  // the capture one cycle after the index edge, together with the position.
  always_comb begin
    state_w          = '0;
    state_w.enabled  = lc_en;
    state_w.captured = capt_r;
    state_w.cont_tog = tog_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      index_d_r <= 1'b0;
      arm_d_r   <= 1'b0;
      armed_r   <= 1'b0;
      capt_r    <= 1'b0;
      tog_r     <= 1'b0;
      pos_r     <= POS_W'(plz_pkg::POS_RST);
    end else begin
      index_d_r <= index_d_nxt;
      arm_d_r   <= arm_d_nxt;
      armed_r   <= armed_nxt;
      capt_r    <= capt_nxt;
      tog_r     <= tog_nxt;
      pos_r     <= pos_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Object access
  // ---------------------------------------------------------------
  // Only the low byte of the latch control is implemented; upper bits
  // are stored but steer nothing.
  always_comb begin
    input_func_nxt = input_func_r;
    latch_ctrl_nxt = latch_ctrl_r;
    // Writes to read-only or unknown indices fall to the default and are
    // dropped without any error answer.
    if (i_obj_wr) begin
      case (i_obj_idx)
        plz_pkg::OBJ_INPUT_FUNC: input_func_nxt = i_obj_wdata[15:0];
        plz_pkg::OBJ_LATCH_CTRL: latch_ctrl_nxt = i_obj_wdata[15:0];
        default: ;
      endcase
    end
    rvalid_nxt = i_obj_rd;
    rdata_nxt  = rdata_r;
    if (i_obj_rd) begin
      case (i_obj_idx)
        plz_pkg::OBJ_INPUT_FUNC:  rdata_nxt = {16'h0000, input_func_r};
        plz_pkg::OBJ_STATUS_WORD: rdata_nxt = {16'h0000, sw_r};
        plz_pkg::OBJ_LATCH_CTRL:  rdata_nxt = {16'h0000, latch_ctrl_r};
        plz_pkg::OBJ_LATCH_STATE: rdata_nxt = state_w;
        plz_pkg::OBJ_LATCH_POS:   rdata_nxt = 32'(pos_r);
        default:                  rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // A read in the same cycle as a write to that object returns the old
  // value; the host sees its write one cycle later.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      input_func_r <= plz_pkg::INPUT_FUNC_RST;
      latch_ctrl_r <= plz_pkg::LATCH_CTRL_RST;
      rdata_r      <= 32'h0000_0000;
      rvalid_r     <= 1'b0;
    end else begin
      input_func_r <= input_func_nxt;
      latch_ctrl_r <= latch_ctrl_nxt;
      rdata_r      <= rdata_nxt;
      rvalid_r     <= rvalid_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a register, so downstream timing sees no decode logic.
  assign o_obj_rdata   = rdata_r;
  assign o_obj_rvalid  = rvalid_r;
  assign o_fb_zero     = zero_r;
  assign o_comp_on     = comp_r;
  assign o_status_word = sw_r;

endmodule : plz_top

// ==== bench/plz_chk.sv ====
// Port checker for the capture and homing block.
`timescale 1ns/1ps
module plz_chk (
  input wire logic                 i_ref_clk,    // Clock.
  input wire logic                 i_rst_b,      // Reset, active low.
  input wire logic                 i_obj_rd,     // Read strobe.
  input wire logic [31:0]          o_obj_rdata,  // Read data.
  input wire logic                 o_obj_rvalid, // Read answer.
  input wire plz_pkg::plz_homing_s i_homing,     // Homing report.
  input wire logic                 o_fb_zero,    // Zero pulse.
  input wire logic                 o_comp_on,    // Compensation on.
  input wire logic [15:0]          o_status_word // Status bits.
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  a_read_answer: assert property (
    i_obj_rd |=> o_obj_rvalid) else $error("read not answered");
  a_answer_pulse: assert property (
    !i_obj_rd |=> !o_obj_rvalid) else $error("stray read answer");
  a_rdata_hold: assert property (
    $past(i_rst_b) && !$past(i_obj_rd) |-> $stable(o_obj_rdata))
    else $error("read data moved without a read");
  a_no_comp: assert property (
    !(i_homing.reached && i_homing.found) |=> !o_comp_on)
    else $error("compensation before homing done");
  a_comp_status: assert property (
    o_comp_on |-> o_status_word[15] && o_status_word[12] &&
    o_status_word[10]) else $error("status bits missing");
  a_zero_on_rise: assert property (
    $rose(o_comp_on) |-> o_fb_zero) else $error("no zero pulse");
  a_zero_cause: assert property (
    o_fb_zero |-> $rose(o_comp_on)) else $error("stray zero pulse");
  a_status_lag: assert property (
    $past(i_rst_b) |-> o_status_word[10] == $past(i_homing.reached) &&
    o_status_word[12] == $past(i_homing.found))
    else $error("status bits do not track homing");
endmodule : plz_chk
bind plz_top plz_chk u_chk (.i_ref_clk, .i_rst_b, .i_obj_rd, .o_obj_rdata,
  .o_obj_rvalid, .i_homing, .o_fb_zero, .o_comp_on, .o_status_word);

// ==== bench/plz_enc_model.sv ====
// Encoder model: moving position, index pulse on request, zero on demand.
`timescale 1ns/1ps
module plz_enc_model (
  input  wire logic  i_clk,   // Clock.
  input  wire logic  i_fire,  // Request an index pulse.
  input  wire logic  i_zero,  // Clear position.
  output logic       o_index, // Index pulse.
  output logic [31:0] o_pos,  // Position.
  output logic [31:0] o_mark  // Position seen at the index rise.
);
  initial begin
    o_index = 1'b0;
    o_pos = 32'h0000_0100;
    o_mark = 32'h0000_0000;
  end
  always @(posedge i_clk) begin
    o_pos <= i_zero ? 32'h0000_0000 : o_pos + 32'h0000_0003;
    o_index <= i_fire;
    if (i_fire && !o_index) o_mark <= o_pos + 32'h0000_0003;
  end
endmodule : plz_enc_model

// ==== bench/tb.sv ====
// Self-checking bench for the capture and homing block.
`timescale 1ns/1ps
module tb;
  logic        i_ref_clk = 1'b0, i_rst_b = 1'b0, fire = 1'b0, idx;
  logic        i_obj_wr = 1'b0, i_obj_rd = 1'b0, o_obj_rvalid;
  logic        o_fb_zero, o_comp_on, c, tog_exp = 1'b0;
  logic [15:0] i_obj_idx = 16'h0000, o_status_word;
  logic [31:0] i_obj_wdata = 32'h0000_0000, o_obj_rdata, pos, mark, last, cmd;
  logic [1:0]  h;
  int          fail_count = 0, num_checks = 0, cyc = 0;
  plz_pkg::plz_homing_s i_homing = '0;
  always #4 i_ref_clk = ~i_ref_clk;
  plz_top uut (.i_ref_clk, .i_rst_b, .i_obj_wr, .i_obj_rd, .i_obj_idx,
    .i_obj_wdata, .o_obj_rdata, .o_obj_rvalid, .i_homing,
    .i_enc_index(idx), .i_fb_pos(pos), .o_fb_zero, .o_comp_on,
    .o_status_word);
  plz_enc_model enc (.i_clk(i_ref_clk), .i_fire(fire), .i_zero(o_fb_zero),
    .o_index(idx), .o_pos(pos), .o_mark(mark));
  function automatic logic [31:0] exp_sw(logic [1:0] hm, logic cb);
    return {16'h0000, hm[1] & hm[0] & cb, 2'b00, hm[0], 1'b0, hm[1], 10'h000};
  endfunction : exp_sw
  task automatic chk(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    i_obj_wr <= 1'b1;
    i_obj_idx <= a;
    i_obj_wdata <= d;
    @(posedge i_ref_clk);
    i_obj_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] m, e);
    i_obj_rd <= 1'b1;
    i_obj_idx <= a;
    @(posedge i_ref_clk);
    i_obj_rd <= 1'b0;
    #1 chk(o_obj_rvalid === 1'b1 && (o_obj_rdata & m) === e, "read");
    @(posedge i_ref_clk);
  endtask : rd
  task automatic pulse();
    repeat (2) @(posedge i_ref_clk);
    fire <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    fire <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : pulse
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(84));
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    rd(16'h60B8, '1, 32'h0);
    rd(16'h60B9, '1, 32'h0);
    rd(16'h60BA, '1, 32'h0);
    rd(16'h1234, '1, 32'h0);
    for (int k = 0; k < 24; k++) begin
      h = 2'($urandom);
      c = 1'($urandom);
      wr(16'h2020, 32'h0);
      i_homing <= h;
      repeat (2) @(posedge i_ref_clk);
      rd(16'h6041, '1, exp_sw(h, 1'b0));
      // The host asks for compensation only once it has seen homing done.
      c = c & h[1] & h[0];
      wr(16'h2020, {31'h0, c});
      repeat (2) @(posedge i_ref_clk);
      rd(16'h6041, '1, exp_sw(h, c));
      rd(16'h2020, '1, {31'h0, c});
      #1 chk(o_comp_on === (h[1] & h[0] & c), "comp");
      cmd = pos;
      chk(!c || cmd < 32'h0000_0040, "not zeroed");
      @(posedge i_ref_clk);
      // Homing may drop while the request stands; compensation follows.
      h = 2'($urandom);
      i_homing <= h;
      repeat (2) @(posedge i_ref_clk);
      #1 chk(o_comp_on === (h[1] & h[0] & c), "comp drop");
      @(posedge i_ref_clk);
    end
    i_homing <= '0;
    wr(16'h2020, 32'h0);
    wr(16'h60B8, 32'h0001);
    wr(16'h60B8, 32'h0011);
    pulse();
    rd(16'h60BA, '1, mark);
    rd(16'h60B9, '1, 32'h3);
    last = mark;
    wr(16'h60BA, 32'h0);
    pulse();
    rd(16'h60BA, '1, last);
    wr(16'h60B8, 32'h0003);
    rd(16'h60B9, 32'h3, 32'h1);
    wr(16'h60B8, 32'h0013);
    repeat (3) begin
      pulse();
      tog_exp = ~tog_exp;
      rd(16'h60BA, '1, mark);
      rd(16'h60B9, '1, {24'h0, tog_exp, 7'h03});
    end
    // A disabled unit reports only its toggle bit and ignores the index.
    last = mark;
    wr(16'h60B8, 32'h0000);
    rd(16'h60B9, '1, {24'h0, tog_exp, 7'h00});
    pulse();
    rd(16'h60BA, '1, last);
    final_report();
  end
endmodule : tb
